/* File: rtl/srq_status_defs.vh */
// constants for the status reporting and message framing block
`ifndef SRQ_STATUS_DEFS_VH
`define SRQ_STATUS_DEFS_VH
// status byte bit positions
`define STB_FAULT_BIT 7
`define STB_SUMMARY_BIT 6
`define STB_EVENT_SUM_BIT 5
`define STB_MSG_AVAIL_BIT 4
`define STB_DEVICE_SUM_BIT 3
`define STB_USED_MASK 8'hb8
// standard event register bit positions
`define SER_POWER_UP_BIT 7
`define SER_CMD_FAULT_BIT 5
`define SER_EXEC_FAULT_BIT 4
`define SER_DEV_FAULT_BIT 3
`define SER_QUERY_FAULT_BIT 2
`define SER_OP_DONE_BIT 0
`define SER_USED_MASK 8'hbd
// reset values
`define SRQ_MASK_RESET 8'h00
`define SER_MASK_RESET 8'h00
`define SER_RESET 8'h80
// characters
`define CHR_LF 8'h0a
`define CHR_CR 8'h0d
`define CHR_SPACE 8'h20
`define CHR_COMMA 8'h2c
`define CHR_SEMI 8'h3b
`define CHR_QUERY 8'h3f
// response terminator select codes
`define TERM_LF 2'h0
`define TERM_CRLF 2'h1
`define TERM_EOI 2'h2
// response data formats
`define FMT_INTEGER 2'h0
`define FMT_FIXED 2'h1
`define FMT_FLOAT 2'h2
`define FMT_ASCII 2'h3
`endif

/* File: rtl/status_reporting_srq.v */
// status byte, service request, standard event register and message framing
// How it works
// [R1] trailing question mark marks a query
// [R2] accept LF, CR+LF, EOI combinations as end
// [R3] response ends LF, CR+LF or EOI; LF default
// [R4] query checked then response requested
// [R5] semicolon splits message units
// [R6] space 20h separates header from data
// [R7] commas separate data items
// [R8] each command fixes its response format
// [R9] status byte masked; any enabled sets bit 6
// [R10] serial link never sets message available
// [R11] status byte is 8 bits, serial poll
// [R12] enabled 0 to 1 sets summary, request
// [R13] poll reads and clears request bit
// [R14] summary bit held until cause cleared
// [R15] status byte bit layout fixed
// [R16] masked event register sets status bit 5
// [R17] clear events on clear, fault query, power
// [R18] power-up flag set at power-on
// [R19] command fault bit 5, skip to terminator
// [R20] execution fault sets bit 4
// [R21] internal anomaly sets bit 3
// [R22] queue fault sets bit 2, flushes queue
// [R23] operation done flag after prior messages
// [R24] clear command clears all status
// [R25] serial link ignored until remote request
// [R26] unused bits read zero
`timescale 1ns/1ns
`include "srq_status_defs.vh"
module status_reporting_srq (
  // clock and reset
  input wire i_core_clk,
  input wire i_rst_b,
  // incoming message bytes from the link receiver
  input wire i_rx_valid,
  input wire [7:0] i_rx_data,
  input wire i_rx_eoi,
  // link selection and remote request
  input wire i_serial_link,
  input wire i_remote_request,
  // command parser results
  input wire i_hdr_error,
  input wire i_param_count_error,
  input wire i_param_format_error,
  input wire i_unsupported_cmd,
  input wire i_exec_fault,
  input wire i_device_fault,
  input wire [1:0] i_cmd_format,
  input wire i_cmd_done,
  // status commands
  input wire i_clear_status,
  input wire i_fault_query,
  input wire i_op_done_cmd,
  input wire i_pending_empty,
  input wire i_srq_mask_wr,
  input wire i_event_mask_wr,
  input wire [7:0] i_mask_data,
  input wire i_term_select_wr,
  input wire [1:0] i_term_select,
  input wire i_serial_poll,
  input wire i_event_flags_rd,
  // output queue events
  input wire i_queue_not_empty,
  input wire i_empty_read,
  input wire i_queue_overflow,
  input wire i_queue_lost,
  // pin-level conditions, asynchronous
  input wire i_fatal_fault_pin,
  input wire i_device_event_pin,
  // status outputs
  output reg [7:0] o_status_summary_byte,
  output reg [7:0] o_poll_byte,
  output reg [7:0] o_standard_event_flags,
  output reg [7:0] o_service_request_mask,
  output reg [7:0] o_standard_event_mask,
  output reg o_service_request,
  output reg o_queue_flush,
  // framing outputs
  output reg o_unit_end,
  output reg o_msg_end,
  output reg o_is_query,
  output reg o_response_req,
  output reg o_header_end,
  output reg o_item_end,
  output reg o_data_valid,
  output reg [7:0] o_data,
  output reg o_discarding,
  output reg o_remote,
  output reg [1:0] o_term_select,
  output reg [1:0] o_resp_format
);

  // framing states
  localparam ST_HEADER = 2'h0;
  localparam ST_DATA = 2'h1;
  localparam ST_SKIP = 2'h2;

  reg [1:0] fatal_sync;
  reg [1:0] device_sync;
  reg [1:0] state;
  reg [1:0] next_state;
  reg pending_cr;
  reg last_query;
  reg op_done_wait;
  reg prev_enabled_any;
  reg [7:0] event_flags;
  reg [7:0] srq_mask;
  reg [7:0] event_mask;
  reg request_service;

  reg [7:0] status_raw;
  reg [7:0] event_set;

  wire rx_ok;
  wire cmd_fault;
  wire enabled_any;
  wire event_clear;
  wire is_term;
  wire unit_query;
  wire device_only;
  wire query_fault;
  wire op_done_now;

  // a byte ends the message on lf, or whenever eoi rides on it
  function ends_message;
    input [7:0] b;
    input eoi;
    begin
      ends_message = (b == `CHR_LF) | eoi;
    end
  endfunction

  // content byte, as opposed to a cr or lf delimiter
  function is_payload;
    input [7:0] b;
    begin
      is_payload = (b != `CHR_LF) && (b != `CHR_CR);
    end
  endfunction

  // two flip-flops before any logic sees the pins
  always @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      fatal_sync <= 2'h0;
      device_sync <= 2'h0;
    end else begin
      fatal_sync <= {fatal_sync[0], i_fatal_fault_pin};
      device_sync <= {device_sync[0], i_device_event_pin};
    end
  end

  // serial link stays dead until the remote request arrives
  assign rx_ok = i_rx_valid & (~i_serial_link | o_remote); // [R25]
  // bare cr is held back: it may start cr+lf
  assign is_term = ends_message(i_rx_data, i_rx_eoi); // [R2]
  // eoi may ride on the last content byte, which then decides the query test
  assign unit_query = (i_rx_eoi & is_payload(i_rx_data) & (state != ST_SKIP)) ?
                      (i_rx_data == `CHR_QUERY) : last_query; // [R1]
  assign cmd_fault = i_hdr_error | i_param_count_error | i_param_format_error | i_unsupported_cmd;

  always @* begin
    next_state = state;
    if (rx_ok) begin
      if (is_term) begin
        next_state = ST_HEADER;
      end else if (state == ST_SKIP) begin
        next_state = ST_SKIP; // [R19]
      end else if (i_rx_data == `CHR_SEMI) begin
        next_state = ST_HEADER; // [R5]
      end else if (state == ST_HEADER && i_rx_data == `CHR_SPACE) begin
        next_state = ST_DATA; // [R6]
      end
    end
    if (cmd_fault) begin
      next_state = ST_SKIP; // [R19]
    end
  end

  always @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state <= ST_HEADER;
      pending_cr <= 1'b0;
      last_query <= 1'b0;
      o_unit_end <= 1'b0;
      o_msg_end <= 1'b0;
      o_is_query <= 1'b0;
      o_response_req <= 1'b0;
      o_header_end <= 1'b0;
      o_item_end <= 1'b0;
      o_data_valid <= 1'b0;
      o_data <= 8'h00;
      o_discarding <= 1'b0;
      o_remote <= 1'b0;
    end else begin
      state <= next_state;
      o_discarding <= (next_state == ST_SKIP);
      o_unit_end <= 1'b0;
      o_msg_end <= 1'b0;
      o_response_req <= 1'b0;
      o_header_end <= 1'b0;
      o_item_end <= 1'b0;
      o_data_valid <= 1'b0;
      if (i_serial_link & i_remote_request) begin
        o_remote <= 1'b1; // [R25]
      end
      if (rx_ok) begin
        if (is_term || i_rx_data == `CHR_CR) begin
          pending_cr <= (i_rx_data == `CHR_CR) & ~i_rx_eoi;
        end else begin
          pending_cr <= 1'b0;
        end
        if (is_term || (i_rx_data == `CHR_SEMI && state != ST_SKIP)) begin
          o_unit_end <= 1'b1; // [R5]
          o_msg_end <= is_term; // [R2]
          o_is_query <= unit_query; // [R1]
          // syntax was clean, so a query earns a response
          o_response_req <= unit_query & (state != ST_SKIP) & ~cmd_fault; // [R4]
          last_query <= 1'b0;
        end else if (i_rx_data == `CHR_CR) begin
          last_query <= last_query;
        end else if (state != ST_SKIP) begin
          last_query <= (i_rx_data == `CHR_QUERY); // [R1]
          if (state == ST_HEADER && i_rx_data == `CHR_SPACE) begin
            o_header_end <= 1'b1; // [R6]
          end else if (state == ST_DATA && i_rx_data == `CHR_COMMA) begin
            o_item_end <= 1'b1; // [R7]
          end else begin
            o_data_valid <= 1'b1;
            o_data <= i_rx_data;
          end
        end
      end else if (pending_cr & i_serial_link) begin
        // a cr with no lf behind it is dropped; it ends nothing
        pending_cr <= 1'b0;
      end
    end
  end

  // status byte assembled bit by bit; unused bits stay low
  always @* begin
    status_raw = 8'h00;
    status_raw[`STB_FAULT_BIT] = fatal_sync[1]; // [R15]
    status_raw[`STB_EVENT_SUM_BIT] = |(event_flags & event_mask); // [R16]
    // the serial link has no message-available indication
    status_raw[`STB_MSG_AVAIL_BIT] = i_queue_not_empty & ~i_serial_link; // [R10] [R15]
    status_raw[`STB_DEVICE_SUM_BIT] = device_sync[1]; // [R15]
    status_raw = status_raw & `STB_USED_MASK; // [R26]
  end

  assign enabled_any = |(status_raw & srq_mask); // [R9]
  assign event_clear = i_clear_status | i_fault_query; // [R17] [R24]

  // device fault only counts when no command or execution fault claims the cycle
  assign device_only = i_device_fault & ~cmd_fault & ~i_exec_fault; // [R21]
  // an empty read is a fault only on the instrument bus
  assign query_fault = (i_empty_read & ~i_serial_link) | i_queue_overflow | i_queue_lost; // [R22]
  // done waits for earlier messages and a quiet receiver
  assign op_done_now = op_done_wait & i_pending_empty & ~i_rx_valid; // [R23]

  // hardware events into the standard event register
  always @* begin
    event_set = 8'h00;
    event_set[`SER_CMD_FAULT_BIT] = cmd_fault; // [R19]
    event_set[`SER_EXEC_FAULT_BIT] = i_exec_fault; // [R20]
    event_set[`SER_DEV_FAULT_BIT] = device_only; // [R21]
    event_set[`SER_QUERY_FAULT_BIT] = query_fault; // [R22]
    event_set[`SER_OP_DONE_BIT] = op_done_now; // [R23]
  end

  // event register; reading it does not clear it, only clear or fault query
  always @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      event_flags <= `SER_RESET; // [R18]
      o_queue_flush <= 1'b0;
    end else begin
      // set wins over a clear in the same cycle, so no event is lost
      event_flags <= ((event_clear ? 8'h00 : event_flags) | event_set) & `SER_USED_MASK; // [R17] [R26]
      o_queue_flush <= query_fault; // [R22]
    end
  end

  // operation done is armed by its command and fires once
  always @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      op_done_wait <= 1'b0;
    end else if (i_op_done_cmd) begin
      op_done_wait <= 1'b1;
    end else if (op_done_now) begin
      op_done_wait <= 1'b0;
    end
  end

  // mask registers; unused status byte bits cannot be enabled
  always @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      srq_mask <= `SRQ_MASK_RESET;
      event_mask <= `SER_MASK_RESET;
    end else begin
      if (i_srq_mask_wr) begin
        srq_mask <= i_mask_data & `STB_USED_MASK;
      end
      if (i_event_mask_wr) begin
        event_mask <= i_mask_data;
      end
    end
  end

  // response terminator and format; terminator code 3 is refused, old setting kept
  always @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_term_select <= `TERM_LF; // [R3]
      o_resp_format <= `FMT_INTEGER;
    end else begin
      if (i_term_select_wr && i_term_select != 2'h3) begin
        o_term_select <= i_term_select; // [R3]
      end
      if (i_cmd_done) begin
        o_resp_format <= i_cmd_format; // [R8]
      end
    end
  end

  // a rise of the enabled summary from none set to any set raises the request; poll clears it
  // the rise wins, so a request is never lost to a poll in the same cycle
  always @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      request_service <= 1'b0;
      prev_enabled_any <= 1'b0;
    end else begin
      prev_enabled_any <= enabled_any;
      if (enabled_any & ~prev_enabled_any) begin
        request_service <= 1'b1; // [R12]
      end else if (i_serial_poll | i_clear_status) begin
        request_service <= 1'b0; // [R13] [R24]
      end
    end
  end

  // registered views of the status state
  always @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_status_summary_byte <= 8'h00;
      o_poll_byte <= 8'h00;
      o_standard_event_flags <= `SER_RESET;
      o_service_request_mask <= `SRQ_MASK_RESET;
      o_standard_event_mask <= `SER_MASK_RESET;
      o_service_request <= 1'b0;
    end else begin
      // summary bit follows cause, no latch
      o_status_summary_byte <= status_raw | {1'b0, enabled_any, 6'h00}; // [R9] [R14] [R11]
      o_poll_byte <= status_raw | {1'b0, request_service, 6'h00}; // [R13] [R11]
      o_standard_event_flags <= event_flags;
      o_service_request_mask <= srq_mask;
      o_standard_event_mask <= event_mask;
      o_service_request <= request_service; // [R13]
    end
  end

endmodule

/* File: tb/srq_status_props.sv */
// assertions on the status reporting block ports
`timescale 1ns/1ns
module srq_status_props (
  input wire i_core_clk, i_rst_b, i_serial_link, i_exec_fault, i_hdr_error,
  input wire i_param_count_error, i_param_format_error, i_unsupported_cmd,
  input wire i_queue_overflow, i_queue_lost, i_empty_read, i_serial_poll, i_term_select_wr,
  input wire [1:0] i_term_select,
  input wire [7:0] o_status_summary_byte, o_standard_event_flags, o_service_request_mask,
  input wire [7:0] o_standard_event_mask,
  input wire o_service_request, o_queue_flush,
  input wire [1:0] o_term_select
);
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_b);
  // one cycle of slack covers the register stage
  a_summary_masked: assert property (($stable(o_service_request_mask) && $stable(o_status_summary_byte & 8'hbf))[*2]
    |-> o_status_summary_byte[6] == |(o_status_summary_byte & o_service_request_mask & 8'hb8))
    else $error("summary bit disagrees with mask");
  a_event_summary: assert property (($stable(o_standard_event_mask) && $stable(o_standard_event_flags))[*2]
    |-> o_status_summary_byte[5] == |(o_standard_event_flags & o_standard_event_mask))
    else $error("event summary disagrees with mask");
  a_unused_zero: assert property (o_status_summary_byte[2:0] == 3'h0 && o_standard_event_flags[6] == 1'b0 &&
    o_standard_event_flags[1] == 1'b0)
    else $error("unused bit set");
  a_serial_no_avail: assert property ($past(i_serial_link) && i_serial_link |-> !o_status_summary_byte[4])
    else $error("message available on serial link");
  a_exec_sets: assert property (i_exec_fault |-> ##[1:2] o_standard_event_flags[4])
    else $error("execution fault not flagged");
  a_cmd_fault: assert property (i_hdr_error || i_param_count_error || i_param_format_error || i_unsupported_cmd
    |-> ##[1:2] o_standard_event_flags[5])
    else $error("command fault not flagged");
  a_query_fault: assert property (i_queue_overflow || i_queue_lost || (i_empty_read && !i_serial_link)
    |-> ##1 o_queue_flush ##1 o_standard_event_flags[2])
    else $error("query fault not flagged or queue kept");
  a_request_rise: assert property ($rose(o_status_summary_byte[6]) |-> ##[0:2] o_service_request)
    else $error("no service request after summary rise");
  a_poll_clears: assert property (i_serial_poll && $stable(o_status_summary_byte) |-> ##[1:2] !o_service_request)
    else $error("poll left request set");
  a_term_refused: assert property (i_term_select_wr && i_term_select == 2'h3 |=> $stable(o_term_select))
    else $error("terminator code 3 accepted");
endmodule
bind status_reporting_srq srq_status_props i_props (.*);

/* File: tb/remote_host.sv */
// remote controller model sending message bytes
`timescale 1ns/1ns
module remote_host (
  input wire i_clk,
  output reg o_rx_valid,
  output reg [7:0] o_rx_data,
  output reg o_rx_eoi
);
  initial begin
    o_rx_valid = 1'b0;
    o_rx_data = 8'h00;
    o_rx_eoi = 1'b0;
  end
  task put(input [7:0] b, input e);
    @(negedge i_clk);
    o_rx_valid = 1'b1;
    o_rx_data = b;
    o_rx_eoi = e;
  endtask
  // t: 0 LF, 1 CR LF, 2 EOI, 3 CR+EOI, 4 LF+EOI, 5 CR LF+EOI
  task send_msg(input string s, input integer t);
    integer i;
    for (i = 0; i < s.len(); i++) put(s[i], t == 2 && i == s.len() - 1);
    if (t == 1 || t == 3 || t == 5) put(8'h0d, t == 3);
    if (t < 2 || t > 3) put(8'h0a, t > 3);
    @(negedge i_clk);
    o_rx_valid = 1'b0;
    o_rx_eoi = 1'b0;
    // idle data must not look like the last byte
    o_rx_data = ~o_rx_data;
  endtask
endmodule

/* File: tb/status_reporting_srq_tb_top.sv */
// self-checking bench for the status reporting block
`timescale 1ns/1ns
module status_reporting_srq_tb_top;
  reg i_core_clk, i_rst_b, i_serial_link, i_pending_empty, i_queue_not_empty, i_event_flags_rd;
  reg i_fatal_fault_pin, i_device_event_pin;
  reg [7:0] i_mask_data;
  reg [1:0] i_term_select, i_cmd_format;
  reg [17:0] p;
  wire i_rx_valid, i_rx_eoi;
  wire [7:0] i_rx_data, o_status_summary_byte, o_poll_byte, o_standard_event_flags, o_service_request_mask;
  wire [7:0] o_standard_event_mask, o_data;
  wire o_service_request, o_queue_flush, o_unit_end, o_msg_end, o_is_query, o_response_req, o_header_end;
  wire o_item_end, o_data_valid, o_discarding, o_remote;
  wire [1:0] o_term_select, o_resp_format;
  wire i_hdr_error = p[0], i_param_count_error = p[1], i_param_format_error = p[2], i_unsupported_cmd = p[3];
  wire i_exec_fault = p[4], i_device_fault = p[5], i_empty_read = p[6], i_queue_overflow = p[7];
  wire i_queue_lost = p[8], i_clear_status = p[9], i_fault_query = p[10], i_serial_poll = p[11];
  wire i_remote_request = p[12], i_op_done_cmd = p[13], i_srq_mask_wr = p[14], i_event_mask_wr = p[15];
  wire i_term_select_wr = p[16], i_cmd_done = p[17];
  integer err_total = 0, total_checks = 0, k, m;
  reg [7:0] n_unit = 0, n_msg = 0, n_resp = 0, n_hdr = 0, n_item = 0, n_dv = 0, n_fl = 0;
  status_reporting_srq i_dut (.*);
  remote_host i_host (.i_clk(i_core_clk), .o_rx_valid(i_rx_valid), .o_rx_data(i_rx_data), .o_rx_eoi(i_rx_eoi));
  always @(posedge i_core_clk) begin
    n_unit <= n_unit + o_unit_end;
    n_msg <= n_msg + o_msg_end;
    n_resp <= n_resp + o_response_req;
    n_hdr <= n_hdr + o_header_end;
    n_item <= n_item + o_item_end;
    n_dv <= n_dv + o_data_valid;
    n_fl <= n_fl + o_queue_flush;
  end
  initial begin
    i_core_clk = 1'b0;
    forever #10 i_core_clk = ~i_core_clk;
  end
  task w(input integer n);
    repeat (n) @(negedge i_core_clk);
  endtask
  task pl(input integer b);
    @(negedge i_core_clk);
    p[b] = 1'b1;
    @(negedge i_core_clk);
    p[b] = 1'b0;
    w(5);
  endtask
  task chk(input [31:0] got, input [31:0] exp);
    total_checks = total_checks + 1;
    if (got !== exp) begin
      err_total = err_total + 1;
      $display("wrong value at %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task wrap_up;
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    #500000;
    err_total = err_total + 1;
    wrap_up;
  end
  initial begin
    {i_rst_b, i_serial_link, i_queue_not_empty, i_event_flags_rd, i_fatal_fault_pin, i_device_event_pin} = 6'h00;
    {i_pending_empty, i_mask_data, i_term_select, i_cmd_format, p} = 0;
    w(16);
    i_rst_b = 1'b1;
    w(1);
    chk(o_standard_event_flags, 8'h80);
    chk(o_status_summary_byte | o_service_request_mask | o_standard_event_mask, 8'h00);
    chk(o_term_select, 8'h00);
    i_host.send_msg("S 1,2;Q?", 1);
    w(4);
    chk({n_unit, n_hdr, n_item}, {8'h02, 8'h01, 8'h01});
    chk({n_msg, n_resp, o_is_query}, {8'h01, 8'h01, 1'b1});
    for (k = 0; k < 6; k++) begin
      m = n_msg;
      i_host.send_msg("Q?", k);
      w(4);
      chk(n_msg, m + 1);
      chk(o_is_query, 1);
    end
    pl(9);
    chk(o_standard_event_flags, 8'h00);
    for (k = 0; k < 9; k++) begin
      m = n_fl;
      pl(k);
      chk(o_standard_event_flags, k < 4 ? 8'h20 : k == 4 ? 8'h10 : k == 5 ? 8'h08 : 8'h04);
      chk(n_fl - m, k > 5);
      if (k < 4) chk(o_discarding, 1);
      i_host.send_msg("", 0);
      pl(9 + k % 2);
      chk(o_standard_event_flags, 8'h00);
    end
    i_mask_data = 8'h10;
    pl(15);
    i_mask_data = 8'h20;
    pl(14);
    chk({o_service_request_mask, o_standard_event_mask}, 16'h2010);
    pl(4);
    chk(o_status_summary_byte, 8'h60);
    chk({o_service_request, o_poll_byte}, 9'h160);
    pl(11);
    chk({o_service_request, o_poll_byte}, 9'h020);
    chk(o_status_summary_byte, 8'h60);
    pl(9);
    chk(o_status_summary_byte, 8'h00);
    i_mask_data = 8'h10;
    pl(14);
    i_queue_not_empty = 1'b1;
    w(4);
    chk({o_service_request, o_status_summary_byte}, 9'h150);
    i_serial_link = 1'b1;
    w(4);
    chk(o_status_summary_byte, 8'h00);
    pl(11);
    pl(6);
    chk(o_standard_event_flags, 8'h00);
    m = n_dv;
    i_host.send_msg("A", 0);
    w(3);
    chk({n_dv, o_remote}, {m[7:0], 1'b0});
    pl(12);
    i_host.send_msg("A", 0);
    w(3);
    chk({n_dv, o_remote}, {m[7:0] + 8'h01, 1'b1});
    chk(o_data, 8'h41);
    {i_serial_link, i_queue_not_empty, i_fatal_fault_pin, i_device_event_pin} = 4'h3;
    w(8);
    chk(o_status_summary_byte, 8'h88);
    {i_fatal_fault_pin, i_device_event_pin} = 2'h0;
    pl(13);
    chk(o_standard_event_flags, 8'h00);
    i_pending_empty = 1'b1;
    w(4);
    chk(o_standard_event_flags, 8'h01);
    for (k = 0; k < 4; k++) begin
      i_term_select = k;
      i_cmd_format = k;
      pl(16);
      pl(17);
      chk({o_term_select, o_resp_format}, {k == 3 ? 2'h2 : k[1:0], k[1:0]});
    end
    wrap_up;
  end
endmodule
